// >>> include/rsp_pkg.sv
// Shared constants and types for the reset source and priority block
`default_nettype none
package rsp_pkg;

  localparam int CLK_PERIOD_PS = 8000;
  localparam int BUS_CYCLE_PS = 250000;
  localparam int E_DIV_DEF = BUS_CYCLE_PS / CLK_PERIOD_PS;
  localparam int DRIVE_ECYC = 4;
  localparam int SAMPLE_ECYC = 2;
  localparam int POR_ECYC_DEF = 4064;
  localparam int WAIT_WAKE_ECYC = 4;
  localparam int CNT_W = 12;
  localparam int DIV_W = 8;

  localparam int AW = 4;
  localparam int DW = 16;
  localparam logic [AW-1:0] OFS_CTRL = 4'h0;
  localparam logic [AW-1:0] OFS_STAT = 4'h4;

  // Status word positions
  localparam int ST_CONV_BIT = 0;
  localparam int ST_BOOT_BIT = 1;
  localparam int ST_SPEC_BIT = 2;
  localparam int ST_MODE_A_BIT = 3;
  localparam int ST_VEC_LSB = 4;
  localparam int ST_WAKE_BIT = 6;

  localparam logic [4:0] PSEL_RST = 5'h06;
  localparam int NM_N = 5;
  localparam int NM_W = 3;
  localparam int MSK_N = 32;
  localparam int MSK_W = 5;

  typedef enum logic [2:0] {
    ST_POR = 3'b000,
    ST_DRIVE = 3'b001,
    ST_REL = 3'b011,
    ST_HOLD = 3'b010,
    ST_RUN = 3'b110
  } rsp_state_e;

  typedef enum logic [1:0] {
    VEC_EXT = 2'h0,
    VEC_CMON = 2'h1,
    VEC_WDOG = 2'h2
  } rsp_vec_e;

  typedef struct packed {
    logic irq_edge;
    logic nvm_prog;
    logic conv_pu;
    logic clk_mon_force;
    logic clk_mon_en;
    logic stop_delay;
    logic [4:0] psel;
  } rsp_ctrl_s;

  localparam int CTRL_W = $bits(rsp_ctrl_s);
  localparam rsp_ctrl_s CTRL_RST = '{
    irq_edge: 1'b0, nvm_prog: 1'b0, conv_pu: 1'b0, clk_mon_force: 1'b0,
    clk_mon_en: 1'b0, stop_delay: 1'b1, psel: PSEL_RST};

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } rsp_bus_s;

  typedef struct packed {
    rsp_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [DIV_W-1:0] div;
    rsp_vec_e src;
    rsp_vec_e vec;
    logic oe;
    logic cpu_rst_n;
    rsp_ctrl_s ctrl;
    logic conv_done;
    logic boot;
    logic special;
    logic mode_a;
    logic wk_busy;
    logic wk_stop;
    logic wake_done;
    logic nmi_v;
    logic [NM_W-1:0] nmi_g;
    logic msk_v;
    logic [MSK_W-1:0] msk_g;
    logic [DW-1:0] rdata;
  } rsp_state_s;

  localparam rsp_state_s STATE_RST = '{
    st: ST_POR, cnt: '0, div: '0, src: VEC_EXT, vec: VEC_EXT,
    oe: 1'b0, cpu_rst_n: 1'b0, ctrl: CTRL_RST, conv_done: 1'b0,
    boot: 1'b0, special: 1'b0, mode_a: 1'b0, wk_busy: 1'b0,
    wk_stop: 1'b0, wake_done: 1'b0, nmi_v: 1'b0, nmi_g: '0,
    msk_v: 1'b0, msk_g: '0, rdata: '0};

endpackage
`default_nettype wire

// >>> hdl/rsp_prio.sv
// Fixed-order priority picker with an optional promoted source
`timescale 1ns/1ps
`default_nettype none
module rsp_prio
  import rsp_pkg::*;
#(
  parameter int N = NM_N,
  parameter int IW = NM_W
)
(
  input wire logic [N-1:0] req,
  input wire logic promote_en,
  input wire logic [IW-1:0] promote,
  output logic valid,
  output logic [IW-1:0] idx
);

  // Lowest index wins unless the promoted source is pending
  always_comb
  begin
    valid = |req;
    idx = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
        idx = IW'(i); // RULE16
    end
    if (promote_en && (int'(promote) < N) && req[promote])
      idx = promote; // RULE18
  end

endmodule
`default_nettype wire

// >>> hdl/rsp_top.sv
// Reset sequencer, reset source detection, reset defaults and priority
//
// Contract
// RULE1 - On any sensed reset, drive reset pin low four bus cycles, then release.
// RULE2 - Sample pin two bus cycles after release; low means external reset.
// RULE3 - Pin high at sample means watchdog or clock-monitor caused it.
// RULE4 - Present the reset vector of the winning source after classification.
// RULE5 - Outside circuit should avoid slow RC delay on the reset pin.
// RULE6 - A low reset pin is recognised in its first low cycle.
// RULE7 - Outside circuit holds pin low eight cycles for external vector.
// RULE8 - Software services the watchdog; a timeout gives a watchdog reset.
// RULE9 - Reset clears converter power-up and conversion-complete flag.
// RULE10 - Reset disables nonvolatile memory programming controls.
// RULE11 - Reset loads priority select with binary 00110.
// RULE12 - Reset leaves the external interrupt pin level sensitive.
// RULE13 - Boot, special and mode-A flags catch mode inputs at reset release.
// RULE14 - Reset sets the stop-delay bit.
// RULE15 - Reset clears both clock-monitor enable bits.
// RULE16 - Non-maskable order: pin/power-on, clock monitor, watchdog, NMI pin, illegal opcode.
// RULE17 - Non-maskable sources ignore the interrupt mask bit.
// RULE18 - Software may promote one maskable source above the rest.
// RULE19 - Software may clear stop-delay; then avoid reset to leave stop.
// RULE20 - Start-up delay always on power-on, never on reset with clocks running.
// RULE21 - Wait-mode recovery completes within four bus cycles.
// RULE22 - Power-on waits 4064 bus cycles, then holds while pin is low.
`timescale 1ns/1ps
`default_nettype none
module rsp_top
  import rsp_pkg::*;
#(
  parameter int E_DIV = E_DIV_DEF,
  parameter int POR_ECYC = POR_ECYC_DEF
)
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [AW-1:0] ADDR,
  input wire logic [DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DW-1:0] RDATA,
  input wire logic RST_PIN_IN,
  output logic RST_PIN_OUT,
  output logic RST_PIN_OE,
  input wire logic WDOG_TIMEOUT,
  input wire logic CLKMON_FAIL,
  input wire logic MODE_SELECT_A_INPUT,
  input wire logic MODE_SELECT_B_INPUT,
  input wire logic NONMASKABLE_INTERRUPT_PIN,
  input wire logic ILLEGAL_OPCODE,
  input wire logic COND_CODE_I_MASK,
  input wire logic [MSK_N-1:0] IRQ_REQ,
  input wire logic STOP_EXIT,
  input wire logic WAIT_EXIT,
  input wire logic CONV_COMPLETE,
  output logic CPU_RST_N,
  output logic [1:0] RST_VECTOR,
  output logic CONVERTER_POWER_UP,
  output logic NVM_PROG_EN,
  output logic CLOCK_MONITOR_ENABLE,
  output logic FORCED_CLOCK_MONITOR_ENABLE,
  output logic STOP_DELAY_ENABLE,
  output logic IRQ_EDGE_MODE,
  output logic BOOT_ROM_SELECT,
  output logic SPECIAL_MODE_FLAG,
  output logic MODE_A_FLAG,
  output logic NMI_VALID,
  output logic [NM_W-1:0] NMI_GRANT,
  output logic MSK_VALID,
  output logic [MSK_W-1:0] MSK_GRANT,
  output logic WAKE_DONE
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release and local signals

  logic rst_meta_q;
  logic rst_n_q;
  rsp_state_s s_q;
  rsp_state_s s_d;
  rsp_bus_s bus;
  logic e_tick;
  logic cmon_hit;
  logic [NM_N-1:0] nm_req;
  logic [MSK_N-1:0] msk_req;
  logic nm_valid;
  logic [NM_W-1:0] nm_idx;
  logic mk_valid;
  logic [MSK_W-1:0] mk_idx;

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign e_tick = (s_q.div == DIV_W'(E_DIV - 1));
  assign cmon_hit = CLKMON_FAIL && (s_q.ctrl.clk_mon_en || s_q.ctrl.clk_mon_force); // RULE15

  ////////////////////////////////////////////////////////////////////////
  // Priority pickers

  // Mask bit gates only the maskable group
  assign nm_req = {ILLEGAL_OPCODE, NONMASKABLE_INTERRUPT_PIN, WDOG_TIMEOUT, cmon_hit, !RST_PIN_IN}; // RULE17
  assign msk_req = IRQ_REQ & {MSK_N{!COND_CODE_I_MASK}};

  rsp_prio #(
    .N(NM_N),
    .IW(NM_W)
  ) u_nm_prio (
    .req(nm_req),
    .promote_en(1'b0),
    .promote('0),
    .valid(nm_valid),
    .idx(nm_idx)
  );

  rsp_prio #(
    .N(MSK_N),
    .IW(MSK_W)
  ) u_mk_prio (
    .req(msk_req),
    .promote_en(1'b1),
    .promote(s_q.ctrl.psel),
    .valid(mk_valid),
    .idx(mk_idx)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    s_d = s_q;
    s_d.div = e_tick ? '0 : s_q.div + DIV_W'(1);
    s_d.wake_done = 1'b0;
    s_d.rdata = '0;
    case (s_q.st)
      ST_POR:
      begin
        // Oscillator settling always applies here
        if (e_tick)
        begin
          if (s_q.cnt == CNT_W'(POR_ECYC - 1))
          begin
            s_d.st = ST_DRIVE; // RULE22 RULE20
            s_d.cnt = '0;
            s_d.oe = 1'b1;
          end
          else
            s_d.cnt = s_q.cnt + CNT_W'(1);
        end
      end
      ST_DRIVE:
      begin
        if (e_tick)
        begin
          if (s_q.cnt == CNT_W'(DRIVE_ECYC - 1))
          begin
            s_d.st = ST_REL; // RULE1
            s_d.cnt = '0;
            s_d.oe = 1'b0;
          end
          else
            s_d.cnt = s_q.cnt + CNT_W'(1);
        end
      end
      ST_REL:
      begin
        if (e_tick)
        begin
          if (s_q.cnt == CNT_W'(SAMPLE_ECYC - 1))
          begin
            s_d.st = ST_HOLD;
            s_d.cnt = '0;
            // Slow pin rise reads as external here
            s_d.vec = RST_PIN_IN ? s_q.src : VEC_EXT; // RULE2 RULE3 RULE4
          end
          else
            s_d.cnt = s_q.cnt + CNT_W'(1);
        end
      end
      ST_HOLD:
      begin
        if (RST_PIN_IN)
        begin
          s_d.st = ST_RUN; // RULE22
          s_d.boot = !MODE_SELECT_B_INPUT; // RULE13
          s_d.special = !MODE_SELECT_B_INPUT;
          s_d.mode_a = MODE_SELECT_A_INPUT;
        end
      end
      ST_RUN:
      begin
        if (!RST_PIN_IN || WDOG_TIMEOUT || cmon_hit)
        begin
          // Running clocks: no oscillator delay
          s_d.st = ST_DRIVE; // RULE6 RULE20
          s_d.cnt = '0;
          s_d.div = '0;
          s_d.oe = 1'b1;
          if (!RST_PIN_IN)
            s_d.src = VEC_EXT;
          else if (cmon_hit)
            s_d.src = VEC_CMON; // RULE16
          else
            s_d.src = VEC_WDOG;
        end
        else if (s_q.wk_busy)
        begin
          if (e_tick)
          begin
            if (!s_q.wk_stop || s_q.cnt == CNT_W'(POR_ECYC - 1))
            begin
              s_d.wk_busy = 1'b0; // RULE21
              s_d.wake_done = 1'b1;
            end
            else
              s_d.cnt = s_q.cnt + CNT_W'(1);
          end
        end
        else if (STOP_EXIT || WAIT_EXIT)
        begin
          s_d.wk_busy = 1'b1;
          s_d.wk_stop = STOP_EXIT && s_q.ctrl.stop_delay; // RULE14
          s_d.cnt = '0;
          s_d.div = '0;
        end
      end
      default:
      begin
        s_d = STATE_RST;
      end
    endcase

    // Register writes, accepted only while running
    if (s_q.st == ST_RUN && bus.wr && bus.addr == OFS_CTRL)
      s_d.ctrl = bus.wdata[CTRL_W-1:0];
    // Hardware set beats write-one clear
    if (s_q.st == ST_RUN && bus.wr && bus.addr == OFS_STAT && bus.wdata[ST_CONV_BIT])
      s_d.conv_done = 1'b0;
    if (CONV_COMPLETE)
      s_d.conv_done = 1'b1;

    s_d.cpu_rst_n = (s_d.st == ST_RUN);
    if (s_d.st != ST_RUN)
    begin
      s_d.ctrl = CTRL_RST; // RULE9 RULE10 RULE11 RULE12 RULE14 RULE15
      s_d.conv_done = 1'b0; // RULE9
      s_d.wk_busy = 1'b0;
    end

    if (bus.rd)
    begin
      case (bus.addr)
        OFS_CTRL:
          s_d.rdata = {{(DW - CTRL_W){1'b0}}, s_q.ctrl};
        OFS_STAT:
        begin
          s_d.rdata[ST_CONV_BIT] = s_q.conv_done;
          s_d.rdata[ST_BOOT_BIT] = s_q.boot;
          s_d.rdata[ST_SPEC_BIT] = s_q.special;
          s_d.rdata[ST_MODE_A_BIT] = s_q.mode_a;
          s_d.rdata[ST_VEC_LSB +: 2] = s_q.vec;
          s_d.rdata[ST_WAKE_BIT] = s_q.wk_busy;
        end
        default:
          s_d.rdata = '0;
      endcase
    end

    s_d.nmi_v = nm_valid; // RULE16 RULE17
    s_d.nmi_g = nm_idx;
    s_d.msk_v = mk_valid; // RULE18
    s_d.msk_g = mk_idx;
  end

  always_ff @(posedge CLK_SYS or negedge rst_n_q)
  begin
    if (!rst_n_q)
      s_q <= STATE_RST;
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign RDATA = s_q.rdata;
  assign RST_PIN_OUT = 1'b0;
  assign RST_PIN_OE = s_q.oe;
  assign CPU_RST_N = s_q.cpu_rst_n;
  assign RST_VECTOR = s_q.vec;
  assign CONVERTER_POWER_UP = s_q.ctrl.conv_pu;
  assign NVM_PROG_EN = s_q.ctrl.nvm_prog;
  assign CLOCK_MONITOR_ENABLE = s_q.ctrl.clk_mon_en;
  assign FORCED_CLOCK_MONITOR_ENABLE = s_q.ctrl.clk_mon_force;
  assign STOP_DELAY_ENABLE = s_q.ctrl.stop_delay;
  assign IRQ_EDGE_MODE = s_q.ctrl.irq_edge;
  assign BOOT_ROM_SELECT = s_q.boot;
  assign SPECIAL_MODE_FLAG = s_q.special;
  assign MODE_A_FLAG = s_q.mode_a;
  assign NMI_VALID = s_q.nmi_v;
  assign NMI_GRANT = s_q.nmi_g;
  assign MSK_VALID = s_q.msk_v;
  assign MSK_GRANT = s_q.msk_g;
  assign WAKE_DONE = s_q.wake_done;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  localparam int DRIVE_CLKS = DRIVE_ECYC * E_DIV;
  localparam int WAKE_MAX = WAIT_WAKE_ECYC * E_DIV;
  logic [CNT_W-1:0] oe_len_q;

  always_ff @(posedge CLK_SYS or negedge rst_n_q)
  begin
    if (!rst_n_q)
      oe_len_q <= '0;
    else
      oe_len_q <= RST_PIN_OE ? oe_len_q + CNT_W'(1) : '0;
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!rst_n_q);

  pin_drive_len_a: assert property ($fell(RST_PIN_OE) |-> oe_len_q == CNT_W'(DRIVE_CLKS)) // RULE1
    else $error("reset pin drive length wrong");
  sample_ext_a: assert property (s_q.st == ST_REL && e_tick && s_q.cnt == CNT_W'(SAMPLE_ECYC - 1)
      && !RST_PIN_IN |=> RST_VECTOR == VEC_EXT) // RULE2
    else $error("external reset not classified");
  sample_int_a: assert property (s_q.st == ST_REL && e_tick && s_q.cnt == CNT_W'(SAMPLE_ECYC - 1)
      && RST_PIN_IN |=> RST_VECTOR == $past(s_q.src)) // RULE3
    else $error("internal reset source lost");
  vector_stable_a: assert property (CPU_RST_N && $past(CPU_RST_N) |-> $stable(RST_VECTOR)) // RULE4
    else $error("vector changed while running");
  pin_low_sense_a: assert property (CPU_RST_N && !RST_PIN_IN |=> RST_PIN_OE && !CPU_RST_N) // RULE6
    else $error("low pin not sensed at once");
  reset_defaults_a: assert property (!CPU_RST_N |-> !CONVERTER_POWER_UP && !NVM_PROG_EN
      && STOP_DELAY_ENABLE && !CLOCK_MONITOR_ENABLE && !FORCED_CLOCK_MONITOR_ENABLE
      && !IRQ_EDGE_MODE && s_q.ctrl.psel == PSEL_RST && !s_q.conv_done) // RULE11
    else $error("reset defaults not applied");
  mode_capture_a: assert property ($rose(CPU_RST_N) |-> MODE_A_FLAG == $past(MODE_SELECT_A_INPUT)
      && SPECIAL_MODE_FLAG == !$past(MODE_SELECT_B_INPUT)) // RULE13
    else $error("mode flags not captured");
  // Sampled reset copy skips the release edge, where the picker flops are still cleared
  nm_order_a: assert property (rst_n_q && !RST_PIN_IN |=> NMI_VALID && NMI_GRANT == '0) // RULE16
    else $error("pin reset not top priority");
  nm_unmasked_a: assert property (COND_CODE_I_MASK && NONMASKABLE_INTERRUPT_PIN |=> NMI_VALID && !MSK_VALID) // RULE17
    else $error("mask bit affects wrong group");
  promote_a: assert property (!COND_CODE_I_MASK && IRQ_REQ[s_q.ctrl.psel]
      |=> MSK_VALID && MSK_GRANT == $past(s_q.ctrl.psel)) // RULE18
    else $error("promoted source not chosen");
  wait_wake_a: assert property (s_q.st == ST_RUN && !s_q.wk_busy && WAIT_EXIT && !STOP_EXIT
      && RST_PIN_IN && !WDOG_TIMEOUT && !cmon_hit |-> ##[1:WAKE_MAX] WAKE_DONE) // RULE21
    else $error("wait recovery too slow");

  ext_reset_c: cover property (s_q.st == ST_REL && e_tick && !RST_PIN_IN);
  wdog_reset_c: cover property ($rose(CPU_RST_N) && RST_VECTOR == VEC_WDOG);
  stop_wake_c: cover property (WAKE_DONE && s_q.wk_stop);

endmodule
`default_nettype wire

// >>> test/rsp_ext_rst.sv
// Model of the outside reset circuit sharing the open-drain reset pin
`timescale 1ns/1ps
`default_nettype none
module rsp_ext_rst
(
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] len,
  input wire logic dev_oe,
  input wire logic dev_out,
  output logic pin
);
  logic [7:0] cnt_q = 8'h00;

  always_ff @(posedge clk)
  begin
    if (start)
      cnt_q <= len;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end

  // Stiff pull-up, no RC: the pin is high the moment every driver lets go
  assign pin = (cnt_q != 8'h00) ? 1'b0 : (dev_oe ? dev_out : 1'b1);
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the reset source and priority block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rsp_pkg::*;
();
  localparam int ED = 2;
  localparam int POR = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0;
  logic [DW-1:0] rdata;
  logic wr = 1'b0, rd = 1'b0, wdog = 1'b0, cmf = 1'b0, mode_a_in = 1'b1, mdb = 1'b0;
  logic nmi = 1'b0, ill = 1'b0, i_mask = 1'b0, stp = 1'b0, wt = 1'b0, conv = 1'b0;
  logic [MSK_N-1:0] irq = '0;
  logic ext_go = 1'b1;
  logic [7:0] ext_len = 8'h3C;
  logic pin, pin_oe, pin_out, cpu_rst_n, conv_pu, nvm, cmon, fcmon, stop_dly, irqe;
  logic boot, spec, mode_a, nmi_v, msk_v, wake;
  logic [1:0] vec;
  logic [NM_W-1:0] nmi_g;
  logic [MSK_W-1:0] msk_g;
  int n_fail = 0, total_checks = 0, cyc = 0, m;

  initial
  begin
    forever #4 clk = ~clk;
  end

  rsp_top #(.E_DIV(ED), .POR_ECYC(POR)) dut_u (
    .CLK_SYS(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .RST_PIN_IN(pin), .RST_PIN_OUT(pin_out), .RST_PIN_OE(pin_oe), .WDOG_TIMEOUT(wdog),
    .CLKMON_FAIL(cmf), .MODE_SELECT_A_INPUT(mode_a_in), .MODE_SELECT_B_INPUT(mdb),
    .NONMASKABLE_INTERRUPT_PIN(nmi), .ILLEGAL_OPCODE(ill), .COND_CODE_I_MASK(i_mask), .IRQ_REQ(irq),
    .STOP_EXIT(stp), .WAIT_EXIT(wt), .CONV_COMPLETE(conv), .CPU_RST_N(cpu_rst_n),
    .RST_VECTOR(vec), .CONVERTER_POWER_UP(conv_pu), .NVM_PROG_EN(nvm),
    .CLOCK_MONITOR_ENABLE(cmon), .FORCED_CLOCK_MONITOR_ENABLE(fcmon),
    .STOP_DELAY_ENABLE(stop_dly), .IRQ_EDGE_MODE(irqe), .BOOT_ROM_SELECT(boot),
    .SPECIAL_MODE_FLAG(spec), .MODE_A_FLAG(mode_a), .NMI_VALID(nmi_v), .NMI_GRANT(nmi_g),
    .MSK_VALID(msk_v), .MSK_GRANT(msk_g), .WAKE_DONE(wake));

  rsp_ext_rst ext_u (.clk(clk), .start(ext_go), .len(ext_len), .dev_oe(pin_oe), .dev_out(pin_out), .pin(pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask

  // Bounded: a stuck sequence shows as a count of 300
  task automatic wait_run(output int n);
    n = 0;
    while (cpu_rst_n !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask

  // f is {mode_a, special, boot}
  task automatic post_rst(input logic [1:0] v, input logic [2:0] f);
    chk(vec, v);
    chk({mode_a, spec, boot}, f);
    chk(conv_pu, 1'b0);
    chk(nvm, 1'b0);
    chk(irqe, 1'b0);
    chk(stop_dly, 1'b1);
    chk({cmon, fcmon}, 2'b00);
    rd_chk(OFS_CTRL, 16'h0026);
    rd_chk(OFS_STAT, {9'h000, 1'b0, v, f, 1'b0});
  endtask

  task automatic rst_seq(input int lat, input logic [1:0] v, input logic [2:0] f);
    int n;
    n = 0;
    @(posedge clk);
    wdog <= 1'b0;
    cmf <= 1'b0;
    ext_go <= 1'b0;
    repeat (lat - 1) @(posedge clk);
    #1 chk({pin_oe, cpu_rst_n}, 2'b10);
    while (pin_oe === 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk);
      #1;
    end
    chk(DW'(n), DW'(4 * ED));
    wait_run(n);
    chk(DW'(n <= 2 * ED + 4), 1);
    post_rst(v, f);
  endtask

  task automatic prio(input logic n_i, input logic i_i, input logic m_i, input logic [MSK_N-1:0] q,
                      input logic [3:0] nexp, input logic [5:0] mexp);
    @(posedge clk);
    nmi <= n_i;
    ill <= i_i;
    i_mask <= m_i;
    irq <= q;
    @(posedge clk);
    #1 chk({nmi_v, nmi_g}, nexp);
    chk({msk_v, msk_g}, mexp);
  endtask

  task automatic wake_chk(input logic s, input int lo, input int hi);
    int n;
    @(posedge clk);
    stp <= s;
    wt <= ~s;
    @(posedge clk);
    stp <= 1'b0;
    wt <= 1'b0;
    n = 1;
    #1;
    while (wake !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk(DW'(n >= lo && n <= hi), 1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      end_sim();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    ext_go <= 1'b0;
    wait_run(m);
    chk(DW'(m >= 60), 1);
    ext_len <= 8'h10;
    post_rst(2'd0, 3'b111);
    prio(1'b0, 1'b0, 1'b0, 32'h0000_0048, 4'h0, 6'h26);
    rd_chk(4'h8, 16'h0000);
    @(posedge clk);
    conv <= 1'b1;
    @(posedge clk);
    conv <= 1'b0;
    rd_chk(OFS_STAT, 16'h000F);
    wr_reg(OFS_CTRL, 16'h07C9);
    #1 chk({irqe, nvm, conv_pu, fcmon, cmon, stop_dly}, 6'b111110);
    rd_chk(OFS_CTRL, 16'h07C9);
    prio(1'b0, 1'b0, 1'b0, 32'h0000_0208, 4'h0, 6'h29);
    prio(1'b0, 1'b0, 1'b1, 32'h0000_0208, 4'h0, 6'h00);
    wake_chk(1'b0, 1, 4 * ED);
    wake_chk(1'b1, 1, 4 * ED);
    @(posedge clk);
    mode_a_in <= 1'b0;
    mdb <= 1'b1;
    cmf <= 1'b1;
    rst_seq(1, 2'd1, 3'b000);
    wake_chk(1'b1, POR * ED - 4, POR * ED + 8);
    @(posedge clk);
    wdog <= 1'b1;
    rst_seq(1, 2'd2, 3'b000);
    wr_reg(OFS_CTRL, 16'h0066);
    @(posedge clk);
    wdog <= 1'b1;
    cmf <= 1'b1;
    rst_seq(1, 2'd1, 3'b000);
    @(posedge clk);
    ext_go <= 1'b1;
    rst_seq(2, 2'd0, 3'b000);
    @(posedge clk);
    ext_go <= 1'b1;
    wdog <= 1'b1;
    // Pin and watchdog start together; a shorter hold keeps release inside the recovery bound
    ext_len <= 8'h0F;
    rst_seq(1, 2'd0, 3'b000);
    prio(1'b1, 1'b1, 1'b1, '0, 4'hB, 6'h00);
    prio(1'b0, 1'b1, 1'b1, '0, 4'hC, 6'h00);
    prio(1'b0, 1'b0, 1'b0, '0, 4'h0, 6'h00);
    end_sim();
  end
endmodule
`default_nettype wire
